// >>> design/ltc_cfg.svh
`ifndef LTC_CFG_SVH
`define LTC_CFG_SVH
// Register byte addresses
`define LTC_AW              12
`define LTC_ADDR_ENABLE     12'h720
`define LTC_ADDR_OFFS_DIR   12'h730
`define LTC_ADDR_REQ_ARB    12'h740
`define LTC_ADDR_SEL_PORT   12'h750
`define LTC_ADDR_IRQ_STAT   12'h7E0
`define LTC_ADDR_IRQ_MASK   12'h7F0
// Enable and status word
`define LTC_GATE_REQ_BIT    56
`define LTC_GATE_PRE_BIT    48
`define LTC_GATE_EN_BIT     40
`define LTC_RDLVL_EN_BIT    32
`define LTC_SEARCH_EN_BIT   24
`define LTC_DONE_BIT        8
// Direction word, group i at bit 8*i, group 8 in the request word
`define LTC_DIR_STEP        8
`define LTC_DIR_GROUPS      9
`define LTC_DIR8_BIT        0
// Request and arbitration word
`define LTC_P1_ORD_LSB      56
`define LTC_P0_ORD_LSB      48
`define LTC_WR_REQ_BIT      40
`define LTC_WR_INTV_BIT     32
`define LTC_WSHARE_BIT      24
`define LTC_LATMODE_BIT     16
`define LTC_RD_REQ_BIT      8
// Select and port word
`define LTC_WR_CS_LSB       56
`define LTC_MODE_LSB        48
`define LTC_RD_CS_LSB       40
`define LTC_P2_WPRI_LSB     32
`define LTC_P2_RPRI_LSB     24
`define LTC_P2_ORD_LSB      16
// Interrupt bits
`define LTC_IRQ_GATE_BIT    0
`define LTC_IRQ_RD_BIT      1
`define LTC_IRQ_WR_BIT      2
`define LTC_IRQ_W           3
// Write leveling spacing in clock cycles
`define LTC_WR_INTV_CYC     16'h0400
`define LTC_INTV_W          16
`endif

// >>> design/ltc_pkg.sv
package ltc_pkg;
  // Kind of training sequence handed to the engine
  typedef enum logic [1:0] {
    LTC_KIND_NONE,
    LTC_KIND_GATE,
    LTC_KIND_READ,
    LTC_KIND_WRITE
  } ltc_kind_e;
  // Sequencer states
  typedef enum logic {
    LTC_ST_IDLE,
    LTC_ST_BUSY
  } ltc_state_e;
endpackage

// >>> design/ltc_leveling_ctrl.sv
`include "ltc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ltc_leveling_ctrl (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // Register port
  input  wire logic [`LTC_AW-1:0]  i_addr,
  input  wire logic [63:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [63:0]         o_rdata,
  // Controller status and training engine
  input  wire logic                i_init_done,
  input  wire logic                i_train_done,
  output logic                     o_train_start,
  output ltc_pkg::ltc_kind_e       o_train_kind,
  output logic      [1:0]          o_train_cs,
  output logic      [1:0]          o_train_mode,
  output logic                     o_busy,
  // Leveling configuration
  output logic                     o_rdlvl_en,
  output logic                     o_rdlvl_search_en,
  output logic                     o_gate_preamble_chk,
  output logic [`LTC_DIR_GROUPS-1:0] o_offset_dir,
  // Arbitration configuration
  output logic                     o_arbiter_pair_weight_share,
  output logic                     o_arbiter_latency_counter_mode,
  output logic      [1:0]          o_port0_reorder_permit,
  // Interrupt
  output logic                     o_irq
);
  import ltc_pkg::*;

  // Configuration registers
  logic                       gate_en_q;
  logic                       gate_pre_q;
  logic                       rdlvl_en_q;
  logic                       search_en_q;
  logic                       done_q;
  logic                       done_d;
  logic [`LTC_DIR_GROUPS-1:0] dir_q;
  logic [1:0]                 p0_ord_q;
  logic [1:0]                 p1_ord_q;
  logic [1:0]                 p2_ord_q;
  logic [1:0]                 p2_wpri_q;
  logic [1:0]                 p2_rpri_q;
  logic                       wr_intv_en_q;
  logic                       wshare_q;
  logic                       latmode_q;
  logic [1:0]                 wr_cs_q;
  logic [1:0]                 rd_cs_q;
  logic [1:0]                 mode_q;
  logic [`LTC_IRQ_W-1:0]      irq_stat_q;
  logic [`LTC_IRQ_W-1:0]      irq_stat_d;
  logic [`LTC_IRQ_W-1:0]      irq_mask_q;
  logic [63:0]                rdata_q;
  // Sequencer
  ltc_state_e                 state_q;
  ltc_state_e                 state_d;
  ltc_kind_e                  kind_q;
  ltc_kind_e                  kind_d;
  logic [1:0]                 cs_q;
  logic [1:0]                 cs_d;
  logic                       start_q;
  logic [2:0]                 pend_q;
  logic [2:0]                 pend_d;
  logic [`LTC_INTV_W-1:0]     intv_q;
  logic [`LTC_INTV_W-1:0]     intv_d;
  logic                       init_q;
  logic                       busy_q;

  // Address decode
  wire sel_en   = (i_addr == `LTC_ADDR_ENABLE);
  wire sel_dir  = (i_addr == `LTC_ADDR_OFFS_DIR);
  wire sel_req  = (i_addr == `LTC_ADDR_REQ_ARB);
  wire sel_sp   = (i_addr == `LTC_ADDR_SEL_PORT);
  wire sel_ist  = (i_addr == `LTC_ADDR_IRQ_STAT);
  wire sel_imk  = (i_addr == `LTC_ADDR_IRQ_MASK);
  wire wr_en    = i_wr & sel_en;
  wire wr_dir   = i_wr & sel_dir;
  wire wr_req   = i_wr & sel_req;
  wire wr_sp    = i_wr & sel_sp;

  // Request strobes live one cycle only; pend_q holds each one until the sequencer takes it
  wire gate_req_pulse = wr_en & i_wdata[`LTC_GATE_REQ_BIT];
  wire rd_req_pulse   = wr_req & i_wdata[`LTC_RD_REQ_BIT]
                        & rdlvl_en_q;
  wire wr_req_pulse   = wr_req & i_wdata[`LTC_WR_REQ_BIT];
  // Auto gate training on the rising edge of init completion
  wire auto_gate      = i_init_done & ~init_q & gate_en_q;

  // Sequencer choice: gate first, then read, then write
  wire wr_ready  = pend_q[2] & (intv_q == '0);
  wire idle      = (state_q == LTC_ST_IDLE);
  wire pick_gate = idle & pend_q[0];
  wire pick_rd   = idle & ~pend_q[0] & pend_q[1];
  wire pick_wr   = idle & ~pend_q[0] & ~pend_q[1] & wr_ready;
  wire pick_any  = pick_gate | pick_rd | pick_wr;
  wire fin       = (state_q == LTC_ST_BUSY) & i_train_done;
  wire [2:0] take = {pick_wr, pick_rd, pick_gate};
  wire [2:0] newr = {wr_req_pulse, rd_req_pulse, gate_req_pulse | auto_gate};

  // Pending requests; a new request beats the clear of a taken one
  assign pend_d = (pend_q & ~take) | newr;

  // Next state of the sequencer
  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    cs_d    = cs_q;
    unique case (state_q)
      LTC_ST_IDLE: begin
        // Priority is settled in the pick wires, one run at a time
        if (pick_any) begin
          state_d = LTC_ST_BUSY;
          if (pick_gate) begin
            kind_d = LTC_KIND_GATE;
            cs_d   = rd_cs_q;
          end else if (pick_rd) begin
            kind_d = LTC_KIND_READ;
            cs_d   = rd_cs_q;
          end else begin
            kind_d = LTC_KIND_WRITE;
            cs_d   = wr_cs_q;
          end
        end
      end
      LTC_ST_BUSY: begin
        if (fin) begin
          state_d = LTC_ST_IDLE;
          kind_d  = LTC_KIND_NONE;
        end
      end
    endcase
  end

  // Interval counter reloads when a write run ends, if spacing is on
  always_comb begin
    intv_d = intv_q;
    if (fin && kind_q == LTC_KIND_WRITE && wr_intv_en_q) begin
      intv_d = `LTC_WR_INTV_CYC;
    end else if (intv_q != '0) begin
      intv_d = intv_q - `LTC_INTV_W'(1);
    end
  end

  // Done flag clears at start, sets when the run finishes
  assign done_d = fin ? 1'b1 : (pick_any ? 1'b0 : done_q);

  // Event bits: completion sets win over software clear
  wire [`LTC_IRQ_W-1:0] ev_set = {fin & (kind_q == LTC_KIND_WRITE),
                                  fin & (kind_q == LTC_KIND_READ),
                                  fin & (kind_q == LTC_KIND_GATE)};
  wire [`LTC_IRQ_W-1:0] ev_clr = (i_wr & sel_ist) ? i_wdata[`LTC_IRQ_W-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~ev_clr) | ev_set;

  // Direction bits per byte group, group 8 sits in the request word
  logic [`LTC_DIR_GROUPS-1:0] dir_d;
  logic [63:0]                dir_word;
  genvar g;
  generate
    for (g = 0; g < `LTC_DIR_GROUPS; g++) begin : g_dir
      if (g < `LTC_DIR_GROUPS - 1) begin : g_lo
        assign dir_d[g] = wr_dir ? i_wdata[g*`LTC_DIR_STEP] : dir_q[g];
        assign dir_word[g*`LTC_DIR_STEP +: `LTC_DIR_STEP] =
          {{(`LTC_DIR_STEP-1){1'b0}}, dir_q[g]};
      end else begin : g_hi
        assign dir_d[g] = wr_req ? i_wdata[`LTC_DIR8_BIT] : dir_q[g];
      end
    end
  endgenerate

  // Read-back words; request bits always read as zero
  wire [63:0] en_word = 64'(
    ({63'h0, gate_pre_q}  << `LTC_GATE_PRE_BIT) |
    ({63'h0, gate_en_q}   << `LTC_GATE_EN_BIT)  |
    ({63'h0, rdlvl_en_q}  << `LTC_RDLVL_EN_BIT) |
    ({63'h0, search_en_q} << `LTC_SEARCH_EN_BIT) |
    ({63'h0, done_q}      << `LTC_DONE_BIT));
  wire [63:0] req_word = 64'(
    ({62'h0, p1_ord_q}     << `LTC_P1_ORD_LSB) |
    ({62'h0, p0_ord_q}     << `LTC_P0_ORD_LSB) |
    ({63'h0, wr_intv_en_q} << `LTC_WR_INTV_BIT) |
    ({63'h0, wshare_q}     << `LTC_WSHARE_BIT) |
    ({63'h0, latmode_q}    << `LTC_LATMODE_BIT) |
    ({63'h0, dir_q[`LTC_DIR_GROUPS-1]} << `LTC_DIR8_BIT));
  wire [63:0] sp_word = 64'(
    ({62'h0, wr_cs_q}   << `LTC_WR_CS_LSB) |
    ({62'h0, mode_q}    << `LTC_MODE_LSB) |
    ({62'h0, rd_cs_q}   << `LTC_RD_CS_LSB) |
    ({62'h0, p2_wpri_q} << `LTC_P2_WPRI_LSB) |
    ({62'h0, p2_rpri_q} << `LTC_P2_RPRI_LSB) |
    ({62'h0, p2_ord_q}  << `LTC_P2_ORD_LSB));
  // Unmapped addresses read zero
  wire [63:0] rd_mux = sel_en  ? en_word :
                       sel_dir ? dir_word :
                       sel_req ? req_word :
                       sel_sp  ? sp_word :
                       sel_ist ? {61'h0, irq_stat_q} :
                       sel_imk ? {61'h0, irq_mask_q} : 64'h0;

  // Enable word; the done bit is not writable
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gate_en_q   <= 1'b0;
      gate_pre_q  <= 1'b0;
      rdlvl_en_q  <= 1'b0;
      search_en_q <= 1'b0;
    end else if (wr_en) begin
      gate_en_q   <= i_wdata[`LTC_GATE_EN_BIT];
      gate_pre_q  <= i_wdata[`LTC_GATE_PRE_BIT];
      rdlvl_en_q  <= i_wdata[`LTC_RDLVL_EN_BIT];
      search_en_q <= i_wdata[`LTC_SEARCH_EN_BIT];
    end
  end

  // Request and arbitration word
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      p0_ord_q     <= 2'h0;
      p1_ord_q     <= 2'h0;
      wr_intv_en_q <= 1'b0;
      wshare_q     <= 1'b0;
      latmode_q    <= 1'b0;
    end else if (wr_req) begin
      p0_ord_q     <= i_wdata[`LTC_P0_ORD_LSB +: 2];
      p1_ord_q     <= i_wdata[`LTC_P1_ORD_LSB +: 2];
      wr_intv_en_q <= i_wdata[`LTC_WR_INTV_BIT];
      wshare_q     <= i_wdata[`LTC_WSHARE_BIT];
      latmode_q    <= i_wdata[`LTC_LATMODE_BIT];
    end
  end

  // Select and port word; port 2 fields are storage only
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_cs_q   <= 2'h0;
      rd_cs_q   <= 2'h0;
      mode_q    <= 2'h0;
      p2_wpri_q <= 2'h0;
      p2_rpri_q <= 2'h0;
      p2_ord_q  <= 2'h0;
    end else if (wr_sp) begin
      wr_cs_q   <= i_wdata[`LTC_WR_CS_LSB +: 2];
      rd_cs_q   <= i_wdata[`LTC_RD_CS_LSB +: 2];
      mode_q    <= i_wdata[`LTC_MODE_LSB +: 2];
      p2_wpri_q <= i_wdata[`LTC_P2_WPRI_LSB +: 2];
      p2_rpri_q <= i_wdata[`LTC_P2_RPRI_LSB +: 2];
      p2_ord_q  <= i_wdata[`LTC_P2_ORD_LSB +: 2];
    end
  end

  // Directions, interrupt state and read data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dir_q      <= '0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      rdata_q    <= 64'h0;
    end else begin
      dir_q      <= dir_d;
      irq_stat_q <= irq_stat_d;
      if (i_wr && sel_imk) begin
        irq_mask_q <= i_wdata[`LTC_IRQ_W-1:0];
      end
      // Read data stands only in the cycle after the strobe
      rdata_q    <= i_rd ? rd_mux : 64'h0;
    end
  end

  // Sequencer registers; busy follows the next state so the port is a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= LTC_ST_IDLE;
      kind_q  <= LTC_KIND_NONE;
      cs_q    <= 2'h0;
      start_q <= 1'b0;
      pend_q  <= 3'h0;
      intv_q  <= '0;
      done_q  <= 1'b0;
      init_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      cs_q    <= cs_d;
      start_q <= pick_any;
      pend_q  <= pend_d;
      intv_q  <= intv_d;
      done_q  <= done_d;
      init_q  <= i_init_done;
      busy_q  <= (state_d == LTC_ST_BUSY);
    end
  end

  // Registered interrupt level
  logic irq_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  // Outputs, all from flip-flops
  assign o_rdata                        = rdata_q;
  assign o_train_start                  = start_q;
  assign o_train_kind                   = kind_q;
  assign o_train_cs                     = cs_q;
  assign o_train_mode                   = mode_q;
  assign o_busy                         = busy_q;
  assign o_rdlvl_en                     = rdlvl_en_q;
  assign o_rdlvl_search_en              = search_en_q;
  assign o_gate_preamble_chk            = gate_pre_q;
  assign o_offset_dir                   = dir_q;
  assign o_arbiter_pair_weight_share    = wshare_q;
  assign o_arbiter_latency_counter_mode = latmode_q;
  assign o_port0_reorder_permit         = p0_ord_q;
  assign o_irq                          = irq_q;
endmodule
`default_nettype wire

// >>> dv/ltc_leveling_ctrl_asserts.sv
`include "ltc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ltc_leveling_ctrl_asserts (
  // Clock, reset and register port
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic [`LTC_AW-1:0] i_addr,
  input wire logic [63:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [63:0]       o_rdata,
  // Training and configuration outputs
  input wire logic              i_train_done,
  input wire logic              o_train_start,
  input var  ltc_pkg::ltc_kind_e o_train_kind,
  input wire logic [1:0]        o_train_cs,
  input wire logic              o_busy,
  input wire logic              o_rdlvl_en,
  input wire logic              o_rdlvl_search_en,
  input wire logic              o_gate_preamble_chk,
  input wire logic [8:0]        o_offset_dir,
  input wire logic              o_arbiter_pair_weight_share,
  input wire logic              o_arbiter_latency_counter_mode,
  input wire logic [1:0]        o_port0_reorder_permit
);
  import ltc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Write decodes and gathered direction bits
  wire       w_en  = i_wr && i_addr == `LTC_ADDR_ENABLE;
  wire       w_dir = i_wr && i_addr == `LTC_ADDR_OFFS_DIR;
  wire       w_arb = i_wr && i_addr == `LTC_ADDR_REQ_ARB;
  wire [7:0] dir_w = {i_wdata[56], i_wdata[48], i_wdata[40], i_wdata[32],
                      i_wdata[24], i_wdata[16], i_wdata[8], i_wdata[0]};
  // Idle request: no run now nor launched by the write edge
  sequence s_req(c);
    c && !o_busy ##1 !o_busy;
  endsequence
  sequence s_end;
    o_busy && i_train_done;
  endsequence
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 64'h0)
    else $error("read data not zero outside answer cycle");
  AST_REQ_RB: assert property (i_rd && i_addr == `LTC_ADDR_REQ_ARB |=>
    !o_rdata[40] && !o_rdata[8]) else $error("request bit reads one");
  AST_DONE_RUN: assert property (i_rd && i_addr == `LTC_ADDR_ENABLE && o_busy |=>
    !o_rdata[8]) else $error("done bit set during run");
  AST_CFG_EN: assert property (w_en |=> o_rdlvl_en == $past(i_wdata[32]) &&
    o_rdlvl_search_en == $past(i_wdata[24]) && o_gate_preamble_chk == $past(i_wdata[48]))
    else $error("enable word bits wrong");
  AST_DIR: assert property (w_dir |=> o_offset_dir[7:0] == $past(dir_w))
    else $error("direction bits wrong");
  AST_ARB: assert property (w_arb |=> o_offset_dir[8] == $past(i_wdata[0]) &&
    o_arbiter_pair_weight_share == $past(i_wdata[24]) &&
    o_arbiter_latency_counter_mode == $past(i_wdata[16]) &&
    o_port0_reorder_permit == $past(i_wdata[49:48])) else $error("arbiter bits wrong");
  AST_START: assert property (o_train_start |-> o_busy && !$past(o_busy) &&
    o_train_kind != LTC_KIND_NONE) else $error("start while busy or without kind");
  AST_HOLD: assert property (o_busy && !i_train_done |=> o_busy &&
    $stable(o_train_kind) && $stable(o_train_cs)) else $error("run changed mid-way");
  AST_END: assert property (s_end |=> !o_busy && o_train_kind == LTC_KIND_NONE)
    else $error("run did not end after done");
  AST_RD_GO: assert property (s_req(w_arb && i_wdata[8] && o_rdlvl_en) |=>
    o_train_start) else $error("read request did not start");
  AST_GATE_GO: assert property (s_req(w_en && i_wdata[56]) |=> o_train_start)
    else $error("gate request did not start");
endmodule
bind ltc_leveling_ctrl ltc_leveling_ctrl_asserts u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_train_done(i_train_done), .o_train_start(o_train_start), .o_train_kind(o_train_kind),
  .o_train_cs(o_train_cs), .o_busy(o_busy), .o_rdlvl_en(o_rdlvl_en),
  .o_rdlvl_search_en(o_rdlvl_search_en), .o_gate_preamble_chk(o_gate_preamble_chk),
  .o_offset_dir(o_offset_dir), .o_arbiter_pair_weight_share(o_arbiter_pair_weight_share),
  .o_arbiter_latency_counter_mode(o_arbiter_latency_counter_mode),
  .o_port0_reorder_permit(o_port0_reorder_permit));
`default_nettype wire

// >>> dv/ltc_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module ltc_engine_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Engine handshake
  input  wire logic       i_start,
  input  wire logic [7:0] i_lat,
  output logic            o_done
);
  logic [7:0] cnt_q;
  logic       run_q;
  // Latency latched at start, so later changes cannot stretch a run
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run_q  <= 1'b0;
      cnt_q  <= 8'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= run_q && cnt_q == 8'h01;
      if (i_start) begin
        run_q <= 1'b1;
        cnt_q <= i_lat;
      end else if (run_q) begin
        cnt_q <= cnt_q - 8'h01;
        run_q <= cnt_q != 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/ltc_leveling_ctrl_tb_top.sv
`include "ltc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ltc_leveling_ctrl_tb_top;
  import ltc_pkg::*;
  localparam logic [11:0] AEN = `LTC_ADDR_ENABLE, ADI = `LTC_ADDR_OFFS_DIR;
  localparam logic [11:0] AAR = `LTC_ADDR_REQ_ARB, ASE = `LTC_ADDR_SEL_PORT;
  localparam logic [11:0] AST = `LTC_ADDR_IRQ_STAT, AMK = `LTC_ADDR_IRQ_MASK;
  localparam logic [63:0] M720 = 64'h0001_0101_0100_0000, M730 = 64'h0101_0101_0101_0101;
  localparam logic [63:0] M740 = 64'h0303_0001_0101_0001, M750 = 64'h0303_0303_0303_0000;
  localparam logic [63:0] GREQ = 64'h0100_0000_0000_0000, WREQ = 64'h0000_0100_0000_0000;
  localparam logic [63:0] B32  = 64'h0000_0001_0000_0000, B8   = 64'h0000_0000_0000_0100;
  logic            i_clk, i_rst_n, i_wr, i_rd, i_init_done, i_train_done, o_train_start;
  logic            o_busy, o_rden, o_srch, o_pre, o_shr, o_latm, o_irq;
  logic            rd_q = 1'b0;
  logic [11:0]     i_addr;
  logic [63:0]     i_wdata, o_rdata, c720, c730, c740, c750, d;
  logic [1:0]      o_train_cs, o_train_mode, o_p0;
  logic [8:0]      o_offset_dir;
  logic [7:0]      lat;
  ltc_kind_e       o_train_kind;
  logic [63:0]     rq[$];
  logic [5:0]      sq[$];
  int              n_errors, check_count, n_start, n0;
  ltc_leveling_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_init_done(i_init_done),
    .i_train_done(i_train_done), .o_train_start(o_train_start), .o_train_kind(o_train_kind),
    .o_train_cs(o_train_cs), .o_train_mode(o_train_mode), .o_busy(o_busy), .o_rdlvl_en(o_rden),
    .o_rdlvl_search_en(o_srch), .o_gate_preamble_chk(o_pre), .o_offset_dir(o_offset_dir),
    .o_arbiter_pair_weight_share(o_shr), .o_arbiter_latency_counter_mode(o_latm),
    .o_port0_reorder_permit(o_p0), .o_irq(o_irq));
  ltc_engine_model u_eng (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(o_train_start),
    .i_lat(lat), .o_done(i_train_done));
  // Free-running 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict();
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bus cycles: one-cycle strobes, launched after a rising edge
  task automatic wr(input logic [11:0] a, input logic [63:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [63:0] e);
    rq.push_back(e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
  endtask
  // Request a run and note the start it must produce
  task automatic go(input ltc_kind_e k, input logic [1:0] cs, input logic [11:0] a,
                    input logic [63:0] v);
    lat <= 8'($urandom_range(20, 6));
    sq.push_back({k, cs, c750[49:48]});
    wr(a, v);
  endtask
  // Sampled mid-cycle so registered outputs have settled
  task automatic wait_idle();
    for (int k = 0; k < 3000 && (sq.size() != 0 || o_busy !== 1'b0); k++) @(negedge i_clk);
    chk("idle", {63'(sq.size()), o_busy}, 64'h0);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Monitor: oldest note against each read answer and each run start
  always @(posedge i_clk) begin
    if (rd_q) chk("rdata", o_rdata, rq.size() ? rq.pop_front() : 64'hDEAD);
    if (o_train_start === 1'b1) begin
      n_start++;
      chk("busy", 64'(o_busy), 64'h1);
      chk("start", 64'({o_train_kind, o_train_cs, o_train_mode}),
          sq.size() ? 64'(sq.pop_front()) : 64'hDEAD);
    end
    rd_q <= i_rd;
  end
  // Hang guard, far beyond the roughly 1400 cycles the run needs
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_init_done, i_addr, i_wdata} = '0;
    lat = 8'h06;
    n_errors = 0;
    check_count = 0;
    n_start = 0;
    void'($urandom(39));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Unmapped write ignored, then every word reads zero
    wr(12'h7A0, {$urandom, $urandom});
    rd(AEN, 64'h0); rd(ADI, 64'h0); rd(AAR, 64'h0); rd(ASE, 64'h0);
    rd(AST, 64'h0); rd(AMK, 64'h0); rd(12'h7A0, 64'h0);
    // Random configuration with request bits clear; done bit written but ignored
    d = {$urandom, $urandom} & ~GREQ | B32 | 64'h0000_0100_0000_0000;
    wr(AEN, d);
    c720 = d & M720;
    d = {$urandom, $urandom};
    wr(ADI, d);
    c730 = d & M730;
    d = {$urandom, $urandom} & ~(WREQ | B8 | B32);
    wr(AAR, d);
    c740 = d & M740;
    d = {$urandom, $urandom};
    wr(ASE, d);
    c750 = d & M750;
    rd(AEN, c720); rd(ADI, c730); rd(AAR, c740); rd(ASE, c750);
    settle(1);
    chk("en", 64'({o_rden, o_srch, o_pre}), 64'({c720[32], c720[24], c720[48]}));
    for (int g = 0; g < 8; g++) chk("dir", 64'(o_offset_dir[g]), 64'(c730[8*g]));
    chk("arb", 64'({o_shr, o_latm, o_p0, o_offset_dir[8]}),
        64'({c740[24], c740[16], c740[49:48], c740[0]}));
    // Read run, done bit, interrupt and its clearing
    wr(AMK, 64'h7);
    go(LTC_KIND_READ, c750[41:40], AAR, c740 | B8);
    wait_idle();
    rd(AEN, c720 | B8);
    rd(AST, 64'h2);
    settle(1);
    chk("irq", 64'(o_irq), 64'h1);
    wr(AST, 64'h7);
    settle(2);
    chk("irq_clr", 64'(o_irq), 64'h0);
    // Write runs on every chip select and mode
    for (int i = 0; i < 4; i++) begin
      c750[57:56] = 2'(i);
      c750[49:48] = 2'(3 - i);
      wr(ASE, c750);
      go(LTC_KIND_WRITE, 2'(i), AAR, c740 | WREQ);
      wait_idle();
    end
    // Requests during a run wait; gate outranks read
    go(LTC_KIND_WRITE, c750[57:56], AAR, c740 | WREQ);
    go(LTC_KIND_GATE, c750[41:40], AEN, c720 | GREQ);
    go(LTC_KIND_READ, c750[41:40], AAR, c740 | B8);
    rd(AEN, c720);
    wait_idle();
    // Read request dropped while read leveling is off
    wr(AEN, c720 & ~B32);
    n0 = n_start;
    wr(AAR, c740 | B8);
    settle(20);
    chk("rd_off", 64'(n_start), 64'(n0));
    wr(AEN, c720);
    // Interval holds the next write run back
    c740 = c740 | B32;
    wr(AAR, c740);
    go(LTC_KIND_WRITE, c750[57:56], AAR, c740 | WREQ);
    wait_idle();
    n0 = n_start;
    go(LTC_KIND_WRITE, c750[57:56], AAR, c740 | WREQ);
    settle(1000);
    chk("intv", 64'(n_start), 64'(n0));
    wait_idle();
    // Masked event keeps interrupt low until unmasked
    wr(AST, 64'h7);
    wr(AMK, 64'h0);
    go(LTC_KIND_GATE, c750[41:40], AEN, c720 | GREQ);
    wait_idle();
    settle(3);
    chk("irq_mask", 64'(o_irq), 64'h0);
    rd(AST, 64'h1);
    wr(AMK, 64'h1);
    settle(3);
    chk("irq_unmask", 64'(o_irq), 64'h1);
    // Automatic gate training when init completes
    wr(AST, 64'h7);
    sq.push_back({LTC_KIND_GATE, c750[41:40], c750[49:48]});
    @(posedge i_clk);
    i_init_done <= 1'b1;
    wait_idle();
    settle(3);
    chk("irq_auto", 64'(o_irq), 64'h1);
    settle(3);
    give_verdict();
  end
endmodule
`default_nettype wire
